// ==== triple_timer_event_counter.sv ====
// three down-counting timers with capture, first and third with toggle, apb slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module triple_timer_event_counter (
  input wire logic sys_clk, // 50 mhz, taken as the oscillator
  input wire logic sys_rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high writes
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb transfer done
  output logic pslverr, // apb unmapped address
  input wire logic timer_a_event_input, // A1 event pin
  input wire logic timer_b_event_input, // A2 event pin
  input wire logic capture_a_input, // A3 capture pin
  input wire logic capture_b_input, // A4 capture pin
  input wire logic capture_c_input, // A5 capture pin
  input wire logic cpu_idle, // processor idle state
  output logic [1:0] port_b_out, // B1..B0 pin levels
  output logic timer_a_interrupt, // first timer flag
  output logic timer_b_interrupt, // second timer flag
  output logic timer_c_interrupt // third timer flag
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = (i >= timer_pkg::A_HIGH_IDX &&
                 i <= timer_pkg::C_CTRL_IDX) ||
                i == timer_pkg::EDGE_IDX ||
                i == timer_pkg::PORT_B_IDX ||
                i == timer_pkg::STATUS_IDX;
  endfunction

  function automatic timer_pkg::chain_t load_chain(
    input logic [4:0] p, input logic [15:0] d);
    load_chain.pre = p;
    load_chain.dec = d;
  endfunction

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [9:0] idx;
  logic access;
  logic mapped;
  logic done;
  logic wr_en;
  logic rd_sample;
  assign idx = paddr[11:2];
  assign access = psel & penable;
  assign mapped = is_mapped(idx);
  assign done = access & pready;
  assign wr_en = done & pwrite & mapped;
  // read data and side effects are sampled one edge before pready
  assign rd_sample = access & ~pready & ~pwrite & mapped;

  timer_pkg::timer_cfg_t cfg [3];
  timer_pkg::chain_t ch [3];
  logic [15:0] cap [3];
  logic [7:0] edge_ctrl;
  logic [7:0] high_latch;
  logic [2:0] flag;
  logic [1:0] div_cnt;
  logic base_tick;
  logic [2:0] tick;
  logic [2:0] wrap;
  logic [2:0] start;
  logic [2:0] ext_tick;
  logic [4:0] new_pre [3];
  logic [2:0] cap_in;
  logic [2:0] cap_prev;
  logic [2:0] cap_pol;
  logic a1_prev;
  logic a2_prev;
  logic [7:0] rd_mux;

  // ---------------------------------------------------------------
  // quarter-rate base clock
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end
  assign base_tick = div_cnt == timer_pkg::DIV_LAST;

  // event pins are synchronous; a rising edge is one step
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      a1_prev <= 1'b0;
      a2_prev <= 1'b0;
    end else begin
      a1_prev <= timer_a_event_input;
      a2_prev <= timer_b_event_input;
    end
  end
  assign ext_tick[0] = timer_a_event_input & ~a1_prev;
  assign ext_tick[1] = timer_b_event_input & ~a2_prev;
  // one step per second-timer wrap, never more
  assign ext_tick[2] = wrap[1];

  // ---------------------------------------------------------------
  // start strobes; the prescaler reload comes from the same write
  // ---------------------------------------------------------------
  assign start[0] = wr_en && idx == timer_pkg::A_CTRL0_IDX &&
                    pwdata[timer_pkg::RUN_BIT];
  assign start[1] = wr_en && idx == timer_pkg::B_CTRL_IDX &&
                    pwdata[timer_pkg::RUN_BIT];
  assign start[2] = wr_en && idx == timer_pkg::C_CTRL_IDX &&
                    pwdata[timer_pkg::RUN_BIT];
  assign new_pre[0] = pwdata[4:0];
  assign new_pre[1] = {3'h0, pwdata[1:0]};
  assign new_pre[2] = {3'h0, pwdata[1:0]};

  // ---------------------------------------------------------------
  // three count chains; narrow timers keep zero upper bits
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_chain
      assign tick[g] = cfg[g].run &
                       (cfg[g].src ? ext_tick[g] : base_tick);
      assign wrap[g] = tick[g] && ch[g].pre == 5'h00 &&
                       ch[g].dec == 16'h0000;
      // start beats a wrap in the same cycle; both reload anyway
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          ch[g] <= '0;
        end else if (start[g]) begin
          ch[g] <= load_chain(new_pre[g], cfg[g].dec_rl);
        end else if (wrap[g]) begin
          ch[g] <= load_chain(cfg[g].pre_rl, cfg[g].dec_rl);
        end else if (tick[g]) begin
          if (ch[g].pre == 5'h00) begin
            ch[g].pre <= cfg[g].pre_rl;
            ch[g].dec <= ch[g].dec - 16'h0001;
          end else begin
            ch[g].pre <= ch[g].pre - 5'h01;
          end
        end
      end
      // capture on the programmed edge, frozen while idle
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cap[g] <= 16'h0000;
        end else if (!cpu_idle && (cap_pol[g] ?
                     (cap_in[g] & ~cap_prev[g]) :
                     (~cap_in[g] & cap_prev[g]))) begin
          cap[g] <= ch[g].dec;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // capture pin edge history
  // ---------------------------------------------------------------
  assign cap_in = {capture_c_input, capture_b_input, capture_a_input};
  assign cap_pol = {edge_ctrl[timer_pkg::EDGE_C_BIT],
                    edge_ctrl[timer_pkg::EDGE_B_BIT],
                    edge_ctrl[timer_pkg::EDGE_A_BIT]};
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_prev <= 3'h0;
    end else begin
      cap_prev <= cap_in;
    end
  end

  // ---------------------------------------------------------------
  // software-written configuration
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        cfg[i] <= '0;
      end
      edge_ctrl <= timer_pkg::EDGE_RESET;
    end else if (wr_en) begin
      case (idx)
        timer_pkg::A_HIGH_IDX: begin
          cfg[0].dec_rl[15:8] <= pwdata[7:0];
        end
        timer_pkg::A_LOW_IDX: begin
          cfg[0].dec_rl[7:0] <= pwdata[7:0];
        end
        timer_pkg::A_CTRL0_IDX: begin
          cfg[0].pre_rl <= pwdata[4:0];
          cfg[0].src <= pwdata[timer_pkg::A_SRC_BIT];
          cfg[0].tog <= pwdata[timer_pkg::A_TOG_BIT];
          cfg[0].run <= pwdata[timer_pkg::RUN_BIT];
        end
        timer_pkg::B_DATA_IDX: begin
          cfg[1].dec_rl <= {8'h00, pwdata[7:0]};
        end
        timer_pkg::B_CTRL_IDX: begin
          cfg[1].pre_rl <= {3'h0, pwdata[1:0]};
          cfg[1].src <= pwdata[timer_pkg::B_SRC_BIT];
          cfg[2].tog <= pwdata[timer_pkg::B_TOG_BIT];
          cfg[1].run <= pwdata[timer_pkg::RUN_BIT];
        end
        timer_pkg::C_DATA_IDX: begin
          cfg[2].dec_rl <= {8'h00, pwdata[7:0]};
        end
        timer_pkg::C_CTRL_IDX: begin
          cfg[2].pre_rl <= {3'h0, pwdata[1:0]};
          cfg[2].src <= pwdata[timer_pkg::C_SRC_BIT];
          cfg[2].run <= pwdata[timer_pkg::RUN_BIT];
        end
        timer_pkg::EDGE_IDX: begin
          edge_ctrl <= pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // port b data doubles as the toggle state, so the pin keeps its
  // last toggled level when the toggle is switched off
  // ---------------------------------------------------------------
  logic [1:0] tog_en;
  logic [1:0] tog_hit;
  logic port_wr;
  assign tog_en = {cfg[2].tog, cfg[0].tog};
  // flags and interrupt enables play no part here
  assign tog_hit = tog_en & {wrap[2], wrap[0]};
  assign port_wr = wr_en && idx == timer_pkg::PORT_B_IDX;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_b_out <= timer_pkg::PORT_B_RESET;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (tog_hit[k]) begin
          port_b_out[k] <= ~port_b_out[k];
        end else if (port_wr && !tog_en[k]) begin
          port_b_out[k] <= pwdata[k];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky flags, write one to clear, a new wrap wins
  // ---------------------------------------------------------------
  logic [2:0] flag_clr;
  assign flag_clr = (wr_en && idx == timer_pkg::STATUS_IDX) ?
                    pwdata[2:0] : 3'h0;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= 3'h0;
    end else begin
      flag <= (flag & ~flag_clr) | wrap;
    end
  end
  assign timer_a_interrupt = flag[0];
  assign timer_b_interrupt = flag[1];
  assign timer_c_interrupt = flag[2];

  // ---------------------------------------------------------------
  // read selection; both high-byte addresses return the latch
  // ---------------------------------------------------------------
  always_comb begin
    case (idx)
      timer_pkg::A_HIGH_IDX: rd_mux = high_latch;
      timer_pkg::A_LOW_IDX: rd_mux = ch[0].dec[7:0];
      timer_pkg::A_CTRL0_IDX: rd_mux = cap[0][7:0];
      timer_pkg::A_CAPH_IDX: rd_mux = high_latch;
      timer_pkg::B_DATA_IDX: rd_mux = ch[1].dec[7:0];
      timer_pkg::B_CTRL_IDX: rd_mux = cap[1][7:0];
      timer_pkg::C_DATA_IDX: rd_mux = ch[2].dec[7:0];
      timer_pkg::C_CTRL_IDX: rd_mux = cap[2][7:0];
      timer_pkg::EDGE_IDX: rd_mux = edge_ctrl;
      timer_pkg::PORT_B_IDX: rd_mux = {6'h00, port_b_out};
      timer_pkg::STATUS_IDX: rd_mux = {5'h00, flag};
      default: rd_mux = 8'h00;
    endcase
  end

  // low-byte reads freeze the high byte so a pair reads coherently
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_latch <= 8'h00;
    end else if (rd_sample && idx == timer_pkg::A_LOW_IDX) begin
      high_latch <= ch[0].dec[15:8];
    end else if (rd_sample && idx == timer_pkg::A_CTRL0_IDX) begin
      high_latch <= cap[0][15:8];
    end
  end

  // ---------------------------------------------------------------
  // apb answer: one wait state so every output is a flop
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access && !pready) begin
        prdata <= (pwrite || !mapped) ? 32'h0000_0000 :
                  {24'h00_0000, rd_mux};
      end
    end
  end
endmodule

// ==== timer_pkg.sv ====
// constants and types shared by the triple timer / event counter
package timer_pkg;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [9:0] A_HIGH_IDX = 10'h114;
  localparam logic [9:0] A_LOW_IDX = 10'h115;
  localparam logic [9:0] A_CTRL0_IDX = 10'h116;
  localparam logic [9:0] A_CAPH_IDX = 10'h117;
  localparam logic [9:0] B_DATA_IDX = 10'h118;
  localparam logic [9:0] B_CTRL_IDX = 10'h119;
  localparam logic [9:0] C_DATA_IDX = 10'h11a;
  localparam logic [9:0] C_CTRL_IDX = 10'h11b;
  localparam logic [9:0] EDGE_IDX = 10'h100;
  localparam logic [9:0] PORT_B_IDX = 10'h101;
  localparam logic [9:0] STATUS_IDX = 10'h102;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RUN_BIT = 7;
  localparam int A_TOG_BIT = 6;
  localparam int A_SRC_BIT = 5;
  localparam int B_TOG_BIT = 6;
  localparam int B_SRC_BIT = 5;
  localparam int C_SRC_BIT = 6;
  localparam int EDGE_A_BIT = 1;
  localparam int EDGE_B_BIT = 2;
  localparam int EDGE_C_BIT = 3;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [1:0] PORT_B_RESET = 2'h0;
  localparam int FOSC_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(FOSC_DIV - 1);
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic src;
    logic tog;
    logic [4:0] pre_rl;
    logic [15:0] dec_rl;
  } timer_cfg_t;
  typedef struct packed {
    logic [4:0] pre;
    logic [15:0] dec;
  } chain_t;
endpackage

// ==== event_source.sv ====
// pin-side model: event pulse train for the counting inputs
`timescale 1ns/1ns
module event_source (
  input wire logic sys_clk, // oscillator clock
  input wire logic run, // pulses only while high
  output logic event_pin // event pulse train
);
  logic [2:0] phase;
  // ---------------------------------------------------------------
  // pulse generator
  // ---------------------------------------------------------------
  // eight clocks a period and four high: below quarter rate, wide
  always_ff @(posedge sys_clk) begin
    phase <= run ? phase + 3'h1 : 3'h0;
  end
  assign event_pin = phase[2];
endmodule

// ==== triple_timer_properties.sv ====
// bus handshake and flag properties watched at the timer block ports
`timescale 1ns/1ns
module triple_timer_properties (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb done
  input wire logic pslverr, // apb error
  input wire logic timer_a_interrupt, // first flag
  input wire logic timer_b_interrupt, // second flag
  input wire logic timer_c_interrupt // third flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // flags are sticky, so only a status write may drop them
  wire clr = psel && penable && pready && pwrite
    && paddr == {timer_pkg::STATUS_IDX, 2'h0};
  sequence s_waiting;
    psel && penable && !pready;
  endsequence
  sequence s_read_done;
    pready && !pwrite;
  endsequence
  a_one_wait_state: assert property (s_waiting |=> pready)
    else $error("access not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_error_empty: assert property (pslverr |-> pready && prdata == 0)
    else $error("error without ready or with data");
  a_read_upper_zero: assert property (
    s_read_done |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_flag_a_sticky: assert property (
    $fell(timer_a_interrupt) |-> $past(clr && pwdata[0]))
    else $error("first flag dropped without clear");
  a_flag_b_sticky: assert property (
    $fell(timer_b_interrupt) |-> $past(clr && pwdata[1]))
    else $error("second flag dropped without clear");
  a_flag_c_sticky: assert property (
    $fell(timer_c_interrupt) |-> $past(clr && pwdata[2]))
    else $error("third flag dropped without clear");
endmodule
bind triple_timer_event_counter triple_timer_properties
  triple_timer_properties_inst (.sys_clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .timer_a_interrupt, .timer_b_interrupt, .timer_c_interrupt);

// ==== triple_timer_event_counter_tb.sv ====
// self-checking bench for the triple timer event counter
`timescale 1ns/1ns
module triple_timer_event_counter_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idle = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, ev_run = 1'b0, ev;
  logic [2:0] cap = 3'h0, irq;
  logic [1:0] port_b;
  logic [7:0] v;
  int fails = 0, checks_done = 0, cyc = 0;
  triple_timer_event_counter triple_timer_event_counter_inst (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer_a_event_input(ev),
    .timer_b_event_input(ev), .capture_a_input(cap[0]),
    .capture_b_input(cap[1]), .capture_c_input(cap[2]),
    .cpu_idle(idle), .port_b_out(port_b), .timer_a_interrupt(irq[0]),
    .timer_b_interrupt(irq[1]), .timer_c_interrupt(irq[2]));
  event_source event_source_inst (.sys_clk, .run(ev_run),
    .event_pin(ev));
  always #10 sys_clk = ~sys_clk;
  // hang guard: a run far past its expected length fails
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      complete_run();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one idle edge at the end so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rise(input int i);
    apb(1'b1, timer_pkg::STATUS_IDX, 8'(1 << i));
    do @(posedge sys_clk); while (irq[i] !== 1'b1);
  endtask
  task automatic period(input int i, input int exp);
    int t1;
    rise(i);
    t1 = cyc;
    rise(i);
    chk("flag period", 32'(cyc - t1), 32'(exp));
  endtask
  task automatic pulse(input int i);
    cap[i] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cap[i] <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic regs_test();
    apb(1'b0, timer_pkg::B_DATA_IDX, 8'h00);
    chk("count b reset", rd, 32'h0);
    apb(1'b0, timer_pkg::EDGE_IDX, 8'h00);
    chk("edge reset", rd, 32'(timer_pkg::EDGE_RESET));
    apb(1'b0, 10'h3ff, 8'h00);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask
  // a slow prescaler keeps the count still between start and stop
  task automatic latch_test();
    apb(1'b1, timer_pkg::A_HIGH_IDX, 8'h12);
    apb(1'b1, timer_pkg::A_LOW_IDX, 8'h34);
    apb(1'b1, timer_pkg::A_CTRL0_IDX, 8'h9f);
    apb(1'b1, timer_pkg::A_CTRL0_IDX, 8'h1f);
    apb(1'b1, timer_pkg::EDGE_IDX, 8'h0e);
    pulse(0);
    apb(1'b1, timer_pkg::A_HIGH_IDX, 8'h56);
    apb(1'b1, timer_pkg::A_CTRL0_IDX, 8'h9f);
    apb(1'b1, timer_pkg::A_CTRL0_IDX, 8'h1f);
    apb(1'b0, timer_pkg::A_CTRL0_IDX, 8'h00);
    chk("capture a low", rd, 32'h34);
    apb(1'b0, timer_pkg::A_HIGH_IDX, 8'h00);
    chk("latch via high", rd, 32'h12);
    apb(1'b0, timer_pkg::A_LOW_IDX, 8'h00);
    chk("count a low", rd, 32'h34);
    apb(1'b0, timer_pkg::A_CAPH_IDX, 8'h00);
    chk("latch via capture", rd, 32'h56);
  endtask
  task automatic periods_test();
    apb(1'b1, timer_pkg::B_DATA_IDX, 8'h03);
    apb(1'b1, timer_pkg::B_CTRL_IDX, 8'h81);
    period(1, 32);
    apb(1'b1, timer_pkg::C_DATA_IDX, 8'h01);
    apb(1'b1, timer_pkg::C_CTRL_IDX, 8'hc0);
    period(2, 64);
    apb(1'b1, timer_pkg::C_CTRL_IDX, 8'h82);
    period(2, 24);
    apb(1'b1, timer_pkg::A_HIGH_IDX, 8'h00);
    apb(1'b1, timer_pkg::A_LOW_IDX, 8'h02);
    apb(1'b1, timer_pkg::A_CTRL0_IDX, 8'h82);
    period(0, 36);
    ev_run <= 1'b1;
    apb(1'b1, timer_pkg::A_CTRL0_IDX, 8'ha0);
    period(0, 24);
    apb(1'b1, timer_pkg::B_DATA_IDX, 8'h01);
    apb(1'b1, timer_pkg::B_CTRL_IDX, 8'ha0);
    period(1, 16);
    ev_run <= 1'b0;
    apb(1'b1, timer_pkg::A_CTRL0_IDX, 8'h00);
    apb(1'b1, timer_pkg::B_CTRL_IDX, 8'h00);
    apb(1'b1, timer_pkg::C_CTRL_IDX, 8'h00);
  endtask
  task automatic tog(input int i, input int f, input logic [9:0] d_idx,
    input logic [9:0] t_idx, input logic [7:0] t_on, input logic [7:0] t_off,
    input logic [9:0] c_idx, input logic [7:0] c_run);
    apb(1'b1, timer_pkg::PORT_B_IDX, 8'h00);
    apb(1'b1, d_idx, 8'hff);
    apb(1'b1, t_idx, t_on);
    apb(1'b1, c_idx, c_run);
    chk("pin after start", 32'(port_b[i]), 32'h0);
    rise(f);
    chk("pin after wrap", 32'(port_b[i]), 32'h1);
    apb(1'b1, timer_pkg::PORT_B_IDX, 8'h00);
    chk("pin write ignored", 32'(port_b[i]), 32'h1);
    rise(f);
    chk("pin second wrap", 32'(port_b[i]), 32'h0);
    apb(1'b1, t_idx, t_off);
    chk("pin level kept", 32'(port_b[i]), 32'h0);
    apb(1'b1, timer_pkg::PORT_B_IDX, 8'(1 << i));
    chk("pin by software", 32'(port_b[i]), 32'h1);
    apb(1'b1, c_idx, 8'h00);
  endtask
  task automatic capture_test();
    apb(1'b1, timer_pkg::B_DATA_IDX, 8'h03);
    apb(1'b1, timer_pkg::B_CTRL_IDX, 8'h83);
    apb(1'b1, timer_pkg::B_CTRL_IDX, 8'h03);
    apb(1'b0, timer_pkg::B_DATA_IDX, 8'h00);
    v = rd[7:0];
    repeat (8) @(posedge sys_clk);
    apb(1'b0, timer_pkg::B_DATA_IDX, 8'h00);
    chk("frozen count", rd, 32'(v));
    pulse(1);
    apb(1'b0, timer_pkg::B_CTRL_IDX, 8'h00);
    chk("capture b", rd, 32'(v));
    apb(1'b1, timer_pkg::B_DATA_IDX, 8'h55);
    apb(1'b1, timer_pkg::B_CTRL_IDX, 8'h83);
    apb(1'b1, timer_pkg::B_CTRL_IDX, 8'h03);
    idle <= 1'b1;
    pulse(1);
    idle <= 1'b0;
    apb(1'b0, timer_pkg::B_CTRL_IDX, 8'h00);
    chk("no capture idle", rd, 32'(v));
    apb(1'b0, timer_pkg::C_DATA_IDX, 8'h00);
    v = rd[7:0];
    pulse(2);
    apb(1'b0, timer_pkg::C_CTRL_IDX, 8'h00);
    chk("capture c", rd, 32'(v));
    // falling polarity: a rising pin must leave the latch alone
    apb(1'b1, timer_pkg::EDGE_IDX, 8'h06);
    cap[2] <= 1'b1;
    apb(1'b1, timer_pkg::C_DATA_IDX, 8'h2a);
    apb(1'b1, timer_pkg::C_CTRL_IDX, 8'h83);
    apb(1'b1, timer_pkg::C_CTRL_IDX, 8'h03);
    apb(1'b0, timer_pkg::C_CTRL_IDX, 8'h00);
    chk("no capture on rise", rd, 32'(v));
    cap[2] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, timer_pkg::C_CTRL_IDX, 8'h00);
    chk("capture on fall", rd, 32'h2a);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    regs_test();
    latch_test();
    periods_test();
    tog(0, 0, timer_pkg::A_LOW_IDX, timer_pkg::A_CTRL0_IDX, 8'hc0, 8'h80,
      timer_pkg::A_CTRL0_IDX, 8'hc0);
    tog(1, 2, timer_pkg::C_DATA_IDX, timer_pkg::B_CTRL_IDX, 8'h40, 8'h00,
      timer_pkg::C_CTRL_IDX, 8'h80);
    capture_test();
    complete_run();
  end
endmodule
